// [logic/spo_pkg.sv]
package spo_pkg;
    // register byte addresses
    localparam logic [15:0] ADDR_ADC_WIDTH = 16'h3005;
    localparam logic [15:0] ADDR_WINDOW = 16'h3007;
    localparam logic [15:0] ADDR_FRAME_RATE = 16'h3009;
    localparam logic [15:0] ADDR_PORT_FMT = 16'h3046;
    localparam logic [15:0] ADDR_AUX_A = 16'h3129;
    localparam logic [15:0] ADDR_AUX_B = 16'h317C;
    localparam logic [15:0] ADDR_AUX_C = 16'h31EC;
    localparam logic [15:0] ADDR_PHYS_LANES = 16'h3407;
    localparam logic [15:0] ADDR_DTYPE_LO = 16'h3441;
    localparam logic [15:0] ADDR_DTYPE_HI = 16'h3442;
    localparam logic [15:0] ADDR_LANES = 16'h3443;
    // field positions
    localparam int FMT_MSB = 7;
    localparam int FMT_LSB = 4;
    localparam int WIDTH_BIT = 0;
    localparam int WIN_MSB = 6;
    localparam int WIN_LSB = 4;
    // reset values
    localparam logic RST_ADC_WIDTH = 1'h1;
    localparam logic [2:0] RST_WINDOW = 3'h0;
    localparam logic [1:0] RST_FRAME_RATE = 2'h1;
    localparam logic [3:0] RST_PORT_FMT = 4'hE;
    localparam logic RST_WORD_WIDTH = 1'h1;
    localparam logic [7:0] RST_AUX_A = 8'h1D;
    localparam logic [7:0] RST_AUX_B = 8'h12;
    localparam logic [7:0] RST_AUX_C = 8'h37;
    localparam logic [1:0] RST_PHYS_LANES = 2'h3;
    localparam logic [15:0] RST_DTYPE = 16'h0C0C;
    localparam logic [1:0] RST_LANES = 2'h3;
    // encodings
    localparam logic [3:0] FMT_DIFF_2CH = 4'hD;
    localparam logic [3:0] FMT_DIFF_4CH = 4'hE;
    localparam logic [15:0] DTYPE_RAW10 = 16'h0A0A;
    localparam logic [15:0] DTYPE_RAW12 = 16'h0C0C;
    localparam logic [1:0] LANES_2 = 2'h1;
    localparam logic [1:0] LANES_4 = 2'h3;
    localparam logic [2:0] WIN_1080 = 3'h0;
    localparam logic [2:0] WIN_720 = 3'h1;
    localparam logic [2:0] WIN_CROP = 3'h4;
    localparam logic [1:0] FR_60 = 2'h1;
    localparam logic [1:0] FR_30 = 2'h2;
    localparam logic [10:0] LINES_1080 = 11'h438;
    localparam logic [10:0] LINES_720 = 11'h2D0;
    // pixel and sync codes, 12-bit form; 10-bit form drops two lsbs
    localparam logic [11:0] MAX10 = 12'h3FF;
    localparam logic [11:0] MAX12 = 12'hFFF;
    localparam logic [11:0] SAV_MARK = 12'h800;
    localparam logic [11:0] EAV_MARK = 12'hB60;
    localparam logic [1:0] SYNC_LAST = 2'h3;
    localparam logic [3:0] TOP_BIT12 = 4'hB;
    localparam logic [3:0] TOP_BIT10 = 4'h9;
    // timing
    localparam int LANE_MAX_MBPS = 891;
    localparam int LANE_MIN_BIT_PS = (1000000 + LANE_MAX_MBPS - 1) / LANE_MAX_MBPS;
    localparam logic [1:0] STRAP_WAIT = 2'h3;

    typedef enum logic [1:0] {SPO_IDLE = 2'b00, SPO_SAV = 2'b01, SPO_PIX = 2'b11, SPO_EAV = 2'b10} spo_fsm_t;
    typedef struct packed {logic valid; logic [11:0] data; logic last;} spo_pix_t;
    typedef struct packed {logic [15:0] addr; logic [7:0] wdata; logic wr; logic rd;} spo_reg_req_t;
    typedef struct packed {logic [3:0][11:0] word; logic width12; logic sync;} spo_beat_t;
    typedef struct packed {
        logic sel_s1; logic sel_s2; logic [1:0] rel_cnt; logic strap_done; logic csi;
        logic [3:0] fmt; logic width12; logic adc12; logic [7:0] aux_a; logic [7:0] aux_b; logic [7:0] aux_c;
        logic [2:0] win; logic [1:0] frs; logic [1:0] phys; logic [15:0] dtype; logic [1:0] lanes;
        logic nch4; logic phys4; logic [7:0] rdata; logic rvalid; logic [10:0] win_lines; logic fr60;
        spo_fsm_t fsm; logic [1:0] cnt; logic [1:0] slot; logic [3:0][11:0] acc; logic acc_full; logic acc_last;
        spo_beat_t beat; logic req; logic ack_s1; logic ack_s2; logic pix_ready;
    } spo_core_t;
    typedef struct packed {
        logic req_s1; logic req_s2; logic req_seen; logic ack; logic [2:0] cfg_s1; logic [2:0] cfg_s2;
        spo_beat_t beat; logic active; logic [3:0] bitcnt;
        logic [3:0] pair_dat; logic [3:0] pair_oe; logic [3:0] lane_dat; logic [3:0] lane_oe;
        logic lane_clk; logic lane_clk_oe;
    } spo_link_t;
endpackage

// [logic/spo_pixel_port.sv]
`timescale 1ns/1ps
module spo_pixel_port (
    input wire logic clk,
    input wire logic rst,
    input wire logic link_clk,
    input wire logic interface_select_pin,
    input spo_pkg::spo_reg_req_t reg_req,
    output logic [7:0] reg_rdata,
    output logic reg_rvalid,
    input spo_pkg::spo_pix_t pix_in,
    output logic pix_ready,
    output logic [10:0] win_lines,
    output logic frame_rate_60,
    output logic [3:0] pair_dat,
    output logic [3:0] pair_oe,
    output logic [3:0] lane_dat,
    output logic [3:0] lane_oe,
    output logic lane_clk,
    output logic lane_clk_oe
);
    spo_pkg::spo_core_t s;
    spo_pkg::spo_core_t next_s;
    spo_pkg::spo_link_t l;
    spo_pkg::spo_link_t next_l;
    logic free;
    logic w12;
    logic [1:0] last_slot;
    logic [3:0] lbit;

    function automatic logic lane_ok(logic [1:0] v);
        // prohibited encodings are dropped, the field keeps its old value
        return (v == spo_pkg::LANES_2) || (v == spo_pkg::LANES_4);
    endfunction

    function automatic logic [11:0] sync_word(logic [1:0] k, logic line_start_sync, logic wide);
        logic [11:0] c;
        c = 12'h000;
        if (k == 2'h0) begin
            c = spo_pkg::MAX12;
        end else if (k == spo_pkg::SYNC_LAST) begin
            c = line_start_sync ? spo_pkg::SAV_MARK : spo_pkg::EAV_MARK;
        end
        return wide ? c : {2'h0, c[11:2]};
    endfunction

    function automatic logic [11:0] clip_pix(logic [11:0] d, logic wide, logic lane_mode);
        logic [11:0] mx;
        logic [11:0] v;
        mx = wide ? spo_pkg::MAX12 : spo_pkg::MAX10;
        v = d & mx;
        // extreme codes are kept free for sync words on the pairs only
        if (!lane_mode && v == 12'h000) begin
            v = 12'h001;
        end else if (!lane_mode && v == mx) begin
            v = mx - 12'h001;
        end
        return v;
    endfunction

    function automatic logic [7:0] read_byte(spo_pkg::spo_core_t c, logic [15:0] a);
        case (a)
            spo_pkg::ADDR_ADC_WIDTH: read_byte = {7'h00, c.adc12};
            spo_pkg::ADDR_WINDOW: read_byte = {1'b0, c.win, 4'h0};
            spo_pkg::ADDR_FRAME_RATE: read_byte = {6'h00, c.frs};
            spo_pkg::ADDR_PORT_FMT: read_byte = {c.fmt, 3'h0, c.width12};
            spo_pkg::ADDR_AUX_A: read_byte = c.aux_a;
            spo_pkg::ADDR_AUX_B: read_byte = c.aux_b;
            spo_pkg::ADDR_AUX_C: read_byte = c.aux_c;
            spo_pkg::ADDR_PHYS_LANES: read_byte = {6'h00, c.phys};
            spo_pkg::ADDR_DTYPE_LO: read_byte = c.dtype[7:0];
            spo_pkg::ADDR_DTYPE_HI: read_byte = c.dtype[15:8];
            spo_pkg::ADDR_LANES: read_byte = {6'h00, c.lanes};
            default: read_byte = 8'h00;
        endcase
    endfunction

    assign free = (s.req == s.ack_s2);
    assign w12 = s.csi ? (s.dtype != spo_pkg::DTYPE_RAW10) : s.width12;
    assign last_slot = s.nch4 ? 2'h3 : 2'h1;

    always_comb begin
        next_s = s;
        next_s.sel_s1 = interface_select_pin;
        next_s.sel_s2 = s.sel_s1;
        next_s.ack_s1 = l.ack;
        next_s.ack_s2 = s.ack_s1;
        if (!s.strap_done) begin
            if (s.rel_cnt == spo_pkg::STRAP_WAIT) begin
                next_s.strap_done = 1'b1;
                next_s.csi = !s.sel_s2;
            end else begin
                next_s.rel_cnt = s.rel_cnt + 2'h1;
            end
        end
        next_s.rvalid = 1'b0;
        if (reg_req.wr) begin
            case (reg_req.addr)
                spo_pkg::ADDR_ADC_WIDTH: next_s.adc12 = reg_req.wdata[spo_pkg::WIDTH_BIT];
                spo_pkg::ADDR_WINDOW: next_s.win = reg_req.wdata[spo_pkg::WIN_MSB:spo_pkg::WIN_LSB];
                spo_pkg::ADDR_FRAME_RATE: begin
                    if (reg_req.wdata[1:0] == spo_pkg::FR_60 || reg_req.wdata[1:0] == spo_pkg::FR_30) begin
                        next_s.frs = reg_req.wdata[1:0];
                    end
                end
                spo_pkg::ADDR_PORT_FMT: begin
                    next_s.fmt = reg_req.wdata[spo_pkg::FMT_MSB:spo_pkg::FMT_LSB];
                    next_s.width12 = reg_req.wdata[spo_pkg::WIDTH_BIT];
                end
                spo_pkg::ADDR_AUX_A: next_s.aux_a = reg_req.wdata;
                spo_pkg::ADDR_AUX_B: next_s.aux_b = reg_req.wdata;
                spo_pkg::ADDR_AUX_C: next_s.aux_c = reg_req.wdata;
                spo_pkg::ADDR_PHYS_LANES: begin
                    if (lane_ok(reg_req.wdata[1:0])) begin
                        next_s.phys = reg_req.wdata[1:0];
                    end
                end
                spo_pkg::ADDR_DTYPE_LO: next_s.dtype[7:0] = reg_req.wdata;
                spo_pkg::ADDR_DTYPE_HI: next_s.dtype[15:8] = reg_req.wdata;
                spo_pkg::ADDR_LANES: begin
                    if (lane_ok(reg_req.wdata[1:0])) begin
                        next_s.lanes = reg_req.wdata[1:0];
                    end
                end
                default: next_s.rvalid = 1'b0;
            endcase
        end
        if (reg_req.rd) begin
            next_s.rvalid = 1'b1;
            next_s.rdata = read_byte(s, reg_req.addr);
        end
        next_s.nch4 = next_s.csi ? (next_s.lanes == spo_pkg::LANES_4) : (next_s.fmt == spo_pkg::FMT_DIFF_4CH);
        next_s.phys4 = (next_s.phys == spo_pkg::LANES_4);
        next_s.win_lines = (next_s.win == spo_pkg::WIN_720) ? spo_pkg::LINES_720 : spo_pkg::LINES_1080;
        next_s.fr60 = (next_s.frs == spo_pkg::FR_60);
        case (s.fsm)
            spo_pkg::SPO_IDLE: begin
                if (pix_in.valid) begin
                    next_s.fsm = s.csi ? spo_pkg::SPO_PIX : spo_pkg::SPO_SAV;
                    next_s.cnt = 2'h0;
                end
            end
            spo_pkg::SPO_SAV, spo_pkg::SPO_EAV: begin
                if (free) begin
                    for (int i = 0; i < 4; i++) begin
                        next_s.beat.word[i] = sync_word(s.cnt, s.fsm == spo_pkg::SPO_SAV, w12);
                    end
                    next_s.beat.width12 = w12;
                    next_s.beat.sync = 1'b1;
                    next_s.req = ~s.req;
                    next_s.cnt = s.cnt + 2'h1;
                    if (s.cnt == spo_pkg::SYNC_LAST) begin
                        next_s.fsm = (s.fsm == spo_pkg::SPO_SAV) ? spo_pkg::SPO_PIX : spo_pkg::SPO_IDLE;
                    end
                end
            end
            spo_pkg::SPO_PIX: begin
                if (s.pix_ready && pix_in.valid) begin
                    // clip on pairs, full span on lanes
                    next_s.acc[s.slot] = clip_pix(pix_in.data, w12, s.csi);
                    // cyclic fill; on lanes slot i goes to lane i+1, on pairs slots 0, 1, 2, 3 go to pairs B, C, A, D
                    if (pix_in.last || s.slot == last_slot) begin
                        next_s.acc_full = 1'b1;
                        next_s.acc_last = pix_in.last;
                        for (int i = 0; i < 4; i++) begin
                            if (i > int'(s.slot)) begin
                                next_s.acc[i] = s.csi ? 12'h000 : 12'h001;
                            end
                        end
                    end else begin
                        next_s.slot = s.slot + 2'h1;
                    end
                end
                if (s.acc_full && free) begin
                    next_s.beat.word = s.acc;
                    next_s.beat.width12 = w12;
                    next_s.beat.sync = 1'b0;
                    next_s.req = ~s.req;
                    next_s.acc_full = 1'b0;
                    next_s.slot = 2'h0;
                    if (s.acc_last) begin
                        next_s.fsm = s.csi ? spo_pkg::SPO_IDLE : spo_pkg::SPO_EAV;
                        next_s.cnt = 2'h0;
                    end
                end
            end
            default: next_s.fsm = spo_pkg::SPO_IDLE;
        endcase
        next_s.pix_ready = (next_s.fsm == spo_pkg::SPO_PIX) && !next_s.acc_full;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s <= '0;
            s.adc12 <= spo_pkg::RST_ADC_WIDTH;
            s.win <= spo_pkg::RST_WINDOW;
            s.frs <= spo_pkg::RST_FRAME_RATE;
            s.fmt <= spo_pkg::RST_PORT_FMT;
            s.width12 <= spo_pkg::RST_WORD_WIDTH;
            s.aux_a <= spo_pkg::RST_AUX_A;
            s.aux_b <= spo_pkg::RST_AUX_B;
            s.aux_c <= spo_pkg::RST_AUX_C;
            s.phys <= spo_pkg::RST_PHYS_LANES;
            s.dtype <= spo_pkg::RST_DTYPE;
            s.lanes <= spo_pkg::RST_LANES;
            s.nch4 <= 1'b1;
            s.phys4 <= 1'b1;
            s.win_lines <= spo_pkg::LINES_1080;
            s.fr60 <= 1'b1;
        end else begin
            s <= next_s;
        end
    end

    // link side: one bit per link clock per channel or lane
    assign lbit[0] = l.active & l.beat.word[0][l.bitcnt];
    assign lbit[1] = l.active & l.beat.word[1][l.bitcnt];
    assign lbit[2] = l.active & l.beat.word[2][l.bitcnt];
    assign lbit[3] = l.active & l.beat.word[3][l.bitcnt];

    always_comb begin
        next_l = l;
        next_l.req_s1 = s.req;
        next_l.req_s2 = l.req_s1;
        // config is quasi-static, so a level synchroniser per bit suffices
        next_l.cfg_s1 = {s.phys4, s.nch4, s.csi};
        next_l.cfg_s2 = l.cfg_s1;
        if (l.active) begin
            if (l.bitcnt == 4'h0) begin
                next_l.active = 1'b0;
                next_l.ack = l.req_seen;
            end else begin
                next_l.bitcnt = l.bitcnt - 4'h1;
            end
        end else if (l.req_s2 != l.req_seen) begin
            // beat held stable by the core until ack returns
            next_l.beat = s.beat;
            next_l.active = 1'b1;
            next_l.req_seen = l.req_s2;
            next_l.bitcnt = s.beat.width12 ? spo_pkg::TOP_BIT12 : spo_pkg::TOP_BIT10;
        end
        if (!l.cfg_s2[0]) begin
            next_l.pair_dat = {lbit[3] & l.cfg_s2[1], lbit[1], lbit[0], lbit[2] & l.cfg_s2[1]};
            next_l.pair_oe = {l.cfg_s2[1], 2'b11, l.cfg_s2[1]};
            next_l.lane_dat = 4'h0;
            next_l.lane_oe = 4'h0;
            next_l.lane_clk = 1'b0;
            next_l.lane_clk_oe = 1'b0;
        end else begin
            next_l.pair_dat = 4'h0;
            next_l.pair_oe = 4'h0;
            // lanes 1, 2 always carry data
            next_l.lane_dat[1:0] = lbit[1:0];
            // idle high on connected spare lanes, float otherwise
            next_l.lane_dat[3:2] = l.cfg_s2[1] ? lbit[3:2] : {2{l.cfg_s2[2]}};
            next_l.lane_oe = {{2{l.cfg_s2[1] | l.cfg_s2[2]}}, 2'b11};
            // lane bit rate equals link clock rate, bounded by the clock source
            next_l.lane_clk = l.active ? ~l.lane_clk : 1'b0;
            next_l.lane_clk_oe = 1'b1;
        end
    end

    always_ff @(posedge link_clk or posedge rst) begin
        if (rst) begin
            l <= '0;
        end else begin
            l <= next_l;
        end
    end

    assign reg_rdata = s.rdata;
    assign reg_rvalid = s.rvalid;
    assign pix_ready = s.pix_ready;
    assign win_lines = s.win_lines;
    assign frame_rate_60 = s.fr60;
    assign pair_dat = l.pair_dat;
    assign pair_oe = l.pair_oe;
    assign lane_dat = l.lane_dat;
    assign lane_oe = l.lane_oe;
    assign lane_clk = l.lane_clk;
    assign lane_clk_oe = l.lane_clk_oe;

    strap_pick_a: assert property (@(posedge clk) disable iff (rst)
        (!s.strap_done && s.rel_cnt == spo_pkg::STRAP_WAIT) |=> (s.csi == !$past(s.sel_s2)) && s.strap_done)
        else $error("interface choice does not follow strap");
    fmt_count_a: assert property (@(posedge clk) disable iff (rst)
        (reg_req.wr && reg_req.addr == spo_pkg::ADDR_PORT_FMT && !s.csi) |=>
        s.nch4 == ($past(reg_req.wdata[7:4]) == spo_pkg::FMT_DIFF_4CH))
        else $error("channel count not set by port format");
    pair_map_a: assert property (@(posedge link_clk) disable iff (rst)
        (!l.cfg_s2[0]) |=> (l.pair_oe == {$past(l.cfg_s2[1]), 2'b11, $past(l.cfg_s2[1])}))
        else $error("pair enables wrong for channel count");
    sync_seq_a: assert property (@(posedge clk) disable iff (rst)
        (s.fsm == spo_pkg::SPO_SAV && s.cnt == spo_pkg::SYNC_LAST && free) |=>
        s.fsm == spo_pkg::SPO_PIX && s.beat.sync && s.beat.word[0] == ($past(w12) ? spo_pkg::SAV_MARK : 12'h200))
        else $error("start sync sequence wrong");
    slot_full_a: assert property (@(posedge clk) disable iff (rst)
        (s.pix_ready && pix_in.valid && s.slot == last_slot) |=> s.acc_full && !s.pix_ready)
        else $error("beat not closed after last channel");
    msb_first_a: assert property (@(posedge link_clk) disable iff (rst)
        (l.active && !l.cfg_s2[0] && l.beat.width12 && l.bitcnt == 4'hB) |=> l.pair_dat[1] == $past(l.beat.word[0][11]))
        else $error("first bit on pair B is not the msb");
    lane_drive_a: assert property (@(posedge link_clk) disable iff (rst)
        l.cfg_s2[0] |=> l.lane_oe[1:0] == 2'b11 && l.lane_clk_oe && l.pair_oe == 4'h0)
        else $error("lane mode drive wrong");
    spare_lane_a: assert property (@(posedge link_clk) disable iff (rst)
        (l.cfg_s2[0] && !l.cfg_s2[1]) |=> l.lane_oe[3:2] == {2{$past(l.cfg_s2[2])}} &&
        l.lane_dat[3:2] == {2{$past(l.cfg_s2[2])}})
        else $error("spare lanes neither idle nor floating");
    lane_guard_a: assert property (@(posedge clk) disable iff (rst)
        (reg_req.wr && reg_req.addr == spo_pkg::ADDR_LANES && !lane_ok(reg_req.wdata[1:0])) |=> $stable(s.lanes))
        else $error("prohibited lane count accepted");
    rate_guard_a: assert property (@(posedge clk) disable iff (rst)
        (reg_req.wr && reg_req.addr == spo_pkg::ADDR_FRAME_RATE && reg_req.wdata[0] == reg_req.wdata[1]) |=> $stable(s.frs))
        else $error("prohibited frame rate accepted");
    beat_width_a: assert property (@(posedge clk) disable iff (rst)
        (s.req != $past(s.req) && !s.csi) |-> s.beat.width12 == s.width12)
        else $error("beat width differs from output width");
    pix_clip_a: assert property (@(posedge clk) disable iff (rst)
        (s.acc_full && !s.csi) |-> s.acc[0] != 12'h000 && s.acc[0] != (s.width12 ? spo_pkg::MAX12 : spo_pkg::MAX10))
        else $error("pixel code reached a sync value");
    dtype_pack_a: assert property (@(posedge clk) disable iff (rst)
        (s.req != $past(s.req) && s.csi) |-> s.beat.width12 == (s.dtype != spo_pkg::DTYPE_RAW10))
        else $error("lane packing does not follow data type");
    cover_lvds4_c: cover property (@(posedge clk) disable iff (rst)
        s.fsm == spo_pkg::SPO_EAV && s.nch4 && !s.csi ##1 s.fsm == spo_pkg::SPO_IDLE);
    cover_lvds2_c: cover property (@(posedge clk) disable iff (rst)
        s.fsm == spo_pkg::SPO_PIX && !s.nch4 && !s.csi && s.acc_full);
    cover_csi_c: cover property (@(posedge clk) disable iff (rst)
        s.csi && s.acc_full && s.acc_last ##1 s.fsm == spo_pkg::SPO_IDLE);
    cover_raw10_c: cover property (@(posedge clk) disable iff (rst)
        s.csi && !w12 && s.acc_full && free);
    win_decode_a: assert property (@(posedge clk) disable iff (rst)
        s.win_lines == ((s.win == spo_pkg::WIN_720) ? spo_pkg::LINES_720 : spo_pkg::LINES_1080))
        else $error("window line count does not follow window field");
    // lanes keep the extreme codes, so only the width mask applies
    lane_span_a: assert property (@(posedge clk) disable iff (rst)
        (s.pix_ready && pix_in.valid && s.csi && s.slot == 2'h0) |=>
        s.acc[0] == ($past(pix_in.data) & ($past(w12) ? spo_pkg::MAX12 : spo_pkg::MAX10)))
        else $error("lane pixel code altered");
endmodule

// [tb/spo_rx_model.sv]
`timescale 1ns/1ps
module spo_rx_model (
    input wire logic link_clk,
    input wire logic rst,
    input wire logic [3:0] pair_dat,
    input wire logic [3:0] pair_oe,
    output logic sync_seen,
    output logic [3:0] line_end_cnt
);
    logic [11:0] sh_b;
    logic [11:0] sh_c;
    // a floating pair reads as 0 at the terminated receiver
    always_ff @(posedge link_clk or posedge rst) begin
        if (rst) begin
            sh_b <= 12'h000;
            sh_c <= 12'h000;
            sync_seen <= 1'b0;
            line_end_cnt <= 4'h0;
        end else begin
            sh_b <= {sh_b[10:0], pair_dat[1] & pair_oe[1]};
            sh_c <= {sh_c[10:0], pair_dat[2] & pair_oe[2]};
            // all-ones start word on both channels
            if (&sh_b && &sh_c) begin
                sync_seen <= 1'b1;
            end
            // end word on both channels
            // a 10-bit end word shows this pattern two gap bits later
            if (sh_b == 12'hB60 && sh_c == 12'hB60) begin
                line_end_cnt <= line_end_cnt + 4'h1;
            end
        end
    end
endmodule

// [tb/spo_pixel_port_tb.sv]
`timescale 1ns/1ps
module spo_pixel_port_tb;
    logic clk = 1'b0;
    logic link_clk = 1'b0;
    logic rst = 1'b1;
    logic interface_select_pin = 1'b1;
    spo_pkg::spo_reg_req_t reg_req = '0;
    spo_pkg::spo_pix_t pix_in = '0;
    logic [7:0] reg_rdata;
    logic reg_rvalid, pix_ready, frame_rate_60, lane_clk, lane_clk_oe, sync_seen;
    logic [10:0] win_lines;
    logic [3:0] pair_dat, pair_oe, lane_dat, lane_oe;
    logic [3:0] line_end_cnt;
    int shs;
    int error_cnt = 0;
    int n_compared = 0;
    logic [15:0] ra[12] = '{16'h3005, 16'h3007, 16'h3009, 16'h3046, 16'h3129, 16'h317C, 16'h31EC, 16'h3407,
        16'h3441, 16'h3442, 16'h3443, 16'h3000};
    logic [7:0] rv[12] = '{8'h01, 8'h00, 8'h01, 8'hE1, 8'h1D, 8'h12, 8'h37, 8'h03, 8'h0C, 8'h0C, 8'h03, 8'h00};
    logic [10:0] wl[3] = '{11'h438, 11'h2D0, 11'h438};
    initial forever #2.5 clk = ~clk;
    initial begin
        #7.3;
        forever #15 link_clk = ~link_clk;
    end
    spo_pixel_port i_dut (.clk(clk), .rst(rst), .link_clk(link_clk), .interface_select_pin(interface_select_pin),
        .reg_req(reg_req), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .pix_in(pix_in), .pix_ready(pix_ready),
        .win_lines(win_lines), .frame_rate_60(frame_rate_60), .pair_dat(pair_dat), .pair_oe(pair_oe),
        .lane_dat(lane_dat), .lane_oe(lane_oe), .lane_clk(lane_clk), .lane_clk_oe(lane_clk_oe));
    spo_rx_model i_rx (.link_clk(link_clk), .rst(rst), .pair_dat(pair_dat), .pair_oe(pair_oe),
        .sync_seen(sync_seen), .line_end_cnt(line_end_cnt));
    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask
    function automatic int integ_lines(input int frame, input int shs_set);
        return frame - (shs_set + 1);
    endfunction
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(negedge clk);
        reg_req = '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(negedge clk);
        reg_req.wr = 1'b0;
    endtask
    task automatic rdchk(input logic [15:0] a, input logic [7:0] exp);
        @(negedge clk);
        reg_req = '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(negedge clk);
        reg_req.rd = 1'b0;
        for (int k = 0; k < 3 && reg_rvalid !== 1'b1; k++) @(negedge clk);
        chk("reg_read", {7'h00, reg_rvalid, reg_rdata}, {8'h01, exp});
    endtask
    // valid held across pixels; the edge after a ready negedge takes it
    task automatic push(input logic [11:0] d, input logic l);
        @(negedge clk);
        pix_in = '{valid: 1'b1, data: d, last: l};
        for (int n = 0; n < 4000 && pix_ready !== 1'b1; n++) @(negedge clk);
        chk("pix_ready", pix_ready, 16'h0001);
        @(posedge clk);
    endtask
    task automatic line(input int n);
        for (int i = 0; i < n; i++) push(i == 0 ? 12'hFFF : i == 1 ? 12'h000 : 12'($urandom), i == n - 1);
        @(negedge clk);
        pix_in.valid = 1'b0;
        repeat (300) @(posedge link_clk);
        @(negedge clk);
    endtask
    task automatic conclude();
        if (error_cnt == 0 && n_compared > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    initial begin
        #200000;
        error_cnt++;
        conclude();
    end
    initial begin
        void'($urandom(66482));
        repeat (10) @(posedge clk);
        @(negedge clk) rst = 1'b0;
        foreach (ra[i]) rdchk(ra[i], rv[i]);
        wr(spo_pkg::ADDR_ADC_WIDTH, 8'h00);
        wr(spo_pkg::ADDR_AUX_A, 8'h1D);
        wr(spo_pkg::ADDR_AUX_B, 8'h12);
        wr(spo_pkg::ADDR_AUX_C, 8'h37);
        rdchk(spo_pkg::ADDR_ADC_WIDTH, 8'h00);
        wr(spo_pkg::ADDR_ADC_WIDTH, 8'h01);
        wr(spo_pkg::ADDR_AUX_A, 8'h00);
        wr(spo_pkg::ADDR_AUX_B, 8'h00);
        wr(spo_pkg::ADDR_AUX_C, 8'h0E);
        rdchk(spo_pkg::ADDR_AUX_C, 8'h0E);
        rdchk(spo_pkg::ADDR_ADC_WIDTH, 8'h01);
        wr(spo_pkg::ADDR_LANES, 8'h02);
        wr(spo_pkg::ADDR_FRAME_RATE, 8'h03);
        rdchk(spo_pkg::ADDR_LANES, 8'h03);
        rdchk(spo_pkg::ADDR_FRAME_RATE, 8'h01);
        wr(spo_pkg::ADDR_FRAME_RATE, 8'h02);
        repeat (3) @(negedge clk);
        chk("frame_rate_60", frame_rate_60, 16'h0000);
        foreach (wl[i]) begin
            wr(spo_pkg::ADDR_WINDOW, i == 0 ? 8'h00 : i == 1 ? 8'h10 : 8'h40);
            repeat (3) @(negedge clk);
            chk("win_lines", win_lines, wl[i]);
            shs = 1 + int'($urandom % (wl[i] - 11'h002));
            chk("integ_lines", 16'(integ_lines(win_lines, shs)), 16'(integ_lines(wl[i], shs)));
        end
        wr(spo_pkg::ADDR_DTYPE_LO, 8'h0A);
        wr(spo_pkg::ADDR_DTYPE_HI, 8'h0A);
        rdchk(spo_pkg::ADDR_DTYPE_HI, 8'h0A);
        // format changed while no line runs
        wr(spo_pkg::ADDR_PORT_FMT, 8'hD1);
        line(6);
        chk("sync_seen", sync_seen, 16'h0001);
        chk("pair_oe_2ch", pair_oe, 16'h0006);
        chk("line_end", line_end_cnt, 16'h0001);
        wr(spo_pkg::ADDR_PORT_FMT, 8'hE0);
        line(5);
        chk("pair_oe_4ch", pair_oe, 16'h000F);
        chk("line_end_10bit", line_end_cnt, 16'h0002);
        @(negedge clk) rst = 1'b1;
        interface_select_pin = 1'b0;
        repeat (10) @(negedge clk);
        rst = 1'b0;
        rdchk(spo_pkg::ADDR_PORT_FMT, 8'hE1);
        wr(spo_pkg::ADDR_PHYS_LANES, 8'h01);
        wr(spo_pkg::ADDR_LANES, 8'h01);
        line(4);
        chk("lane_oe_2", {lane_clk_oe, pair_oe, lane_oe}, 16'h0103);
        wr(spo_pkg::ADDR_PHYS_LANES, 8'h03);
        wr(spo_pkg::ADDR_DTYPE_LO, 8'h0A);
        wr(spo_pkg::ADDR_DTYPE_HI, 8'h0A);
        line(3);
        chk("lane_idle", {lane_oe, lane_dat[3:2]}, 16'h003F);
        chk("lane_quiet", {lane_clk, lane_dat[1:0]}, 16'h0000);
        chk("pairs_quiet", line_end_cnt, 16'h0000);
        conclude();
    end
endmodule
